// ===== rtl/spm_pkg.sv
// Purpose: constants and types of the SPI master/slave port
// Assumes: register index times four gives the Avalon byte address
// Notes:   see the list below for the behaviour this block keeps
//
// What this block does
// [RULE_01] Every byte transfer shifts one bit out and one bit in together.
// [RULE_02] As master, writing the data buffer starts a byte with generated clock.
// [RULE_03] As master, after transfer done the data buffer reads the received byte.
// [RULE_04] Data buffer writes load outgoing byte, reads return incoming byte.
// [RULE_05] As slave, software loads the data buffer before the master clocks.
// [RULE_06] As slave with nothing loaded, incoming clocks exchange no data.
// [RULE_07] As slave, received byte is readable when transfer done is raised.
// [RULE_08] Control bit 7 enables the interrupt; resets to zero.
// [RULE_09] Control bit 6 enables the port; resets to zero.
// [RULE_10] Control bit 4 selects master when one; resets to one.
// [RULE_11] Control bit 3 sets the idle serial clock level.
// [RULE_12] Polarity and phase together choose the data transition edge.
// [RULE_13] As master, control bits 1:0 with extension bits select the divider.
// [RULE_14] Slave with polarity equal phase: change on falling, sample on rising.
// [RULE_15] Slave with polarity unequal phase: change on rising, sample on falling.
// [RULE_16] Four-bit code divides system clock: 0010 by 8 up to 1011 by 4096.
// [RULE_17] Transfer done flag sets at each byte end, stays until cleared.
// [RULE_18] Bytes shift most significant bit first.
package spm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] IDX_CTRL = 16'h2540;
  localparam logic [15:0] IDX_STAT = 16'h2541;
  localparam logic [15:0] IDX_DATA = 16'h2542;
  localparam logic [15:0] IDX_EXT  = 16'h2543;
  localparam logic [15:0] IDX_MASK = 16'h2544;
  localparam logic [15:0] ADR_CTRL = {IDX_CTRL[13:0], 2'b00};
  localparam logic [15:0] ADR_STAT = {IDX_STAT[13:0], 2'b00};
  localparam logic [15:0] ADR_DATA = {IDX_DATA[13:0], 2'b00};
  localparam logic [15:0] ADR_EXT  = {IDX_EXT[13:0], 2'b00};
  localparam logic [15:0] ADR_MASK = {IDX_MASK[13:0], 2'b00};

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_PORT_EN = 6;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_CLOCK_IDLE_POLARITY = 3;
  localparam int CTRL_CLOCK_PHASE_SELECT = 2;
  localparam int STAT_DONE = 7;
  localparam int STAT_WCOL = 6;
  localparam logic [7:0] CTRL_WMASK = 8'hDF;
  localparam logic [7:0] EXT_WMASK  = 8'h03;
  localparam logic [7:0] STAT_USED  = 8'hC0;
  localparam logic [7:0] CTRL_RST   = 8'h10;
  localparam logic [7:0] EXT_RST    = 8'h02;
  localparam logic [7:0] MASK_RST   = 8'hFF;
  localparam logic [3:0] LAST_EDGE  = 4'hF;
  localparam logic [3:0] LAST_BIT   = 4'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} spm_state_type;

  typedef struct packed {
    logic sckOut;
    logic sckOe;
    logic sdoOut;
    logic sdoOe;
  } spm_pins_type;

  typedef struct packed {
    spm_state_type st;
    logic [7:0]    ctrl;
    logic [7:0]    ext;
    logic [7:0]    mask;
    logic [7:0]    stat;
    logic [7:0]    txSh;
    logic [7:0]    rxSh;
    logic [7:0]    rxBuf;
    logic          outBit;
    logic          sck;
    logic          sckPrev;
    logic [3:0]    edgeCnt;
    logic [11:0]   divCnt;
    logic          ack;
    logic [7:0]    rdata;
  } spm_regs_type;

  // [RULE_16] divider code table
  // Half period in system clocks; reserved codes fall back to divide by 8
  function automatic logic [11:0] spm_half_period(input logic [3:0] code);
    logic [11:0] h;
    h = 12'h004;
    unique case (code)
      4'h3: h = 12'h010;
      4'h4: h = 12'h020;
      4'h5: h = 12'h008;
      4'h6: h = 12'h040;
      4'h7: h = 12'h080;
      4'h8: h = 12'h100;
      4'h9: h = 12'h200;
      4'hA: h = 12'h400;
      4'hB: h = 12'h800;
      default: h = 12'h004;
    endcase
    return h;
  endfunction : spm_half_period

endpackage : spm_pkg

// ===== rtl/spm_port.sv
// Purpose: byte SPI port, master or slave, behind an Avalon-MM slave
// Assumes: serial inputs are synchronous to ref_clk
// Notes:   one state struct, registered once per clock
`timescale 1ns/1ps
`default_nettype none
module spm_port
  import spm_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // Avalon-MM slave
  input  wire logic [15:0]  address,
  input  wire logic         read,
  input  wire logic         write,
  input  wire logic [31:0]  writedata,
  input  wire logic [3:0]   byteenable,
  output logic      [31:0]  readdata,
  output logic              waitrequest,
  // Serial link
  input  wire logic         sckIn,
  input  wire logic         sdiIn,
  output spm_pins_type      pins,
  // Interrupt
  output logic              irq
);

  spm_regs_type s_q;
  spm_regs_type s_d;

  logic       portEn;
  logic       isMaster;
  logic       clock_idle_polarity;
  logic       clock_phase_select;
  logic       busFire;
  logic       doWr;
  logic       doRd;
  logic       evDone;
  logic       evCol;
  logic       sckRise;
  logic       sckEdge;
  logic       sampleNow;
  logic [11:0] halfPer;

  assign portEn   = s_q.ctrl[CTRL_PORT_EN];
  assign isMaster = s_q.ctrl[CTRL_MASTER];
  assign clock_idle_polarity     = s_q.ctrl[CTRL_CLOCK_IDLE_POLARITY];
  assign clock_phase_select     = s_q.ctrl[CTRL_CLOCK_PHASE_SELECT];
  // [RULE_13] divider code select
  assign halfPer  = spm_half_period({s_q.ext[1:0], s_q.ctrl[1:0]});

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    s_d       = s_q;
    evDone    = 1'b0;
    evCol     = 1'b0;
    sampleNow = 1'b0;
    sckRise   = sckIn & ~s_q.sckPrev;
    sckEdge   = sckIn ^ s_q.sckPrev;
    s_d.sckPrev = sckIn;

    // Bus: one wait cycle, effect at the edge where waitrequest is low
    busFire  = s_q.ack & (read | write);
    doWr     = busFire & write & byteenable[0];
    doRd     = busFire & read;
    s_d.ack  = (read | write) & ~s_q.ack;
    s_d.rdata = 8'h00;
    if ((read | write) & ~s_q.ack)
    begin
      unique case (address)
        ADR_CTRL: s_d.rdata = s_q.ctrl;
        ADR_STAT: s_d.rdata = s_q.stat;
        // [RULE_04] reads return received byte
        ADR_DATA: s_d.rdata = s_q.rxBuf;
        ADR_EXT:  s_d.rdata = s_q.ext;
        ADR_MASK: s_d.rdata = s_q.mask;
        default:  s_d.rdata = 8'h00;
      endcase
    end

    if (doWr)
    begin
      unique case (address)
        // [RULE_08] [RULE_09] [RULE_10] control fields
        ADR_CTRL: s_d.ctrl = writedata[7:0] & CTRL_WMASK;
        ADR_EXT:  s_d.ext  = writedata[7:0] & EXT_WMASK;
        ADR_MASK: s_d.mask = writedata[7:0] & STAT_USED;
        default:  ;
      endcase
    end

    // Data buffer write loads the shifter
    if (doWr && address == ADR_DATA)
    begin
      if (s_q.st != ST_IDLE)
        evCol = 1'b1;
      else if (portEn)
      begin
        s_d.edgeCnt = 4'h0;
        s_d.divCnt  = halfPer - 12'h001;
        // [RULE_18] MSB first; phase 0 presents bit 7 before first edge
        if (!clock_phase_select)
        begin
          s_d.outBit = writedata[7];
          s_d.txSh   = {writedata[6:0], 1'b0};
        end
        else
          s_d.txSh = writedata[7:0];
        // [RULE_02] master starts at once
        if (isMaster)
          s_d.st = ST_MASTER;
        // [RULE_05] slave waits for the far clock
        else
          s_d.st = ST_SLAVE;
      end
    end

    // ****************************************
    // Shift engine
    // ****************************************
    unique case (s_q.st)
      ST_IDLE:
      begin
        // [RULE_11] idle clock level
        s_d.sck = clock_idle_polarity;
      end
      ST_MASTER:
      begin
        if (s_q.divCnt == 12'h000)
        begin
          s_d.divCnt  = halfPer - 12'h001;
          s_d.sck     = ~s_q.sck;
          s_d.edgeCnt = s_q.edgeCnt + 4'h1;
          // [RULE_12] even edges lead; phase picks sample edge
          sampleNow = (s_q.edgeCnt[0] == clock_phase_select);
          if (s_q.edgeCnt == LAST_EDGE)
            evDone = 1'b1;
        end
        else
          s_d.divCnt = s_q.divCnt - 12'h001;
      end
      ST_SLAVE:
      begin
        // [RULE_06] only reached with a byte loaded
        if (sckEdge)
        begin
          // [RULE_14] [RULE_15] sample edge from polarity and phase
          sampleNow = (sckRise == (clock_idle_polarity == clock_phase_select));
          if (sampleNow)
          begin
            s_d.edgeCnt = s_q.edgeCnt + 4'h1;
            if (s_q.edgeCnt == LAST_BIT)
              evDone = 1'b1;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase

    // [RULE_01] sample in, or shift out, on the chosen edge
    if (s_q.st == ST_MASTER || s_q.st == ST_SLAVE)
    begin
      if (sampleNow)
        s_d.rxSh = {s_q.rxSh[6:0], sdiIn};
      else if ((s_q.st == ST_MASTER && s_q.divCnt == 12'h000) || (s_q.st == ST_SLAVE && sckEdge))
      begin
        s_d.outBit = s_q.txSh[7];
        s_d.txSh   = {s_q.txSh[6:0], 1'b0};
      end
    end

    if (evDone)
    begin
      // [RULE_03] [RULE_07] received byte to the buffer at done
      s_d.rxBuf = s_d.rxSh;
      s_d.st    = ST_IDLE;
    end

    if (!portEn)
    begin
      s_d.st  = ST_IDLE;
      s_d.sck = clock_idle_polarity;
    end

    // [RULE_17] sticky flags, read clears, a new event wins
    // Clear only what the read reported, so a later event is kept
    if (doRd && address == ADR_STAT)
      s_d.stat = s_q.stat & ~s_q.rdata;
    if (evDone)
      s_d.stat[STAT_DONE] = 1'b1;
    if (evCol)
      s_d.stat[STAT_WCOL] = 1'b1;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.ctrl    <= CTRL_RST;
      s_q.ext     <= EXT_RST;
      s_q.mask    <= MASK_RST & STAT_USED;
      s_q.sckPrev <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign waitrequest = (read | write) & ~s_q.ack;
  assign readdata    = {24'h000000, s_q.rdata};
  assign pins.sckOut = s_q.sck;
  assign pins.sckOe  = portEn & isMaster;
  assign pins.sdoOut = s_q.outBit;
  // Slave drives its output only while a byte is loaded
  assign pins.sdoOe  = portEn & (isMaster | (s_q.st == ST_SLAVE));
  // [RULE_08] interrupt gate
  assign irq = s_q.ctrl[CTRL_IRQ_EN] & |(s_q.stat & s_q.mask);

endmodule : spm_port
`default_nettype wire

// ===== verif/spm_chk.sv
// Purpose: port checks of spm_port
// Assumes: bound onto spm_port
// Notes:   ctrl_q shadows accepted control writes
`timescale 1ns/1ps
`default_nettype none
module spm_chk
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         rst_b,
  // Register bus
  input wire logic [15:0]  address,
  input wire logic         read,
  input wire logic         write,
  input wire logic [31:0]  writedata,
  input wire logic [3:0]   byteenable,
  input wire logic [31:0]  readdata,
  input wire logic         waitrequest,
  // Link and interrupt
  input wire spm_pins_type pins,
  input wire logic         irq
);
  logic [7:0] ctrl_q;
  logic [7:0] ext_q;
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      ctrl_q <= CTRL_RST;
      ext_q  <= EXT_RST;
    end
    else if (write && !waitrequest && byteenable[0])
    begin
      if (address == ADR_CTRL)
        ctrl_q <= writedata[7:0];
      if (address == ADR_EXT)
        ext_q <= writedata[7:0];
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_ctrlWr;
    write && !waitrequest && address == ADR_CTRL && byteenable[0];
  endsequence
  sequence s_dataWr;
    write && !waitrequest && address == ADR_DATA && byteenable[0];
  endsequence
  property p_oneWait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_oneWait: assert property (p_oneWait) else $error("more than one wait cycle");
  property p_noWait; !(read || write) |-> !waitrequest; endproperty
  a_noWait: assert property (p_noWait) else $error("wait without request");
  property p_rdHigh; read && !waitrequest |-> readdata[31:8] == 24'h0; endproperty
  a_rdHigh: assert property (p_rdHigh) else $error("upper read lanes not zero");
  property p_disable; s_ctrlWr ##0 !writedata[CTRL_PORT_EN] |=> !pins.sckOe && !pins.sdoOe; endproperty
  a_disable: assert property (p_disable) else $error("disabled port drives pins");
  property p_role; s_ctrlWr ##0 writedata[CTRL_PORT_EN] |=> pins.sckOe == $past(writedata[CTRL_MASTER]); endproperty
  a_role: assert property (p_role) else $error("clock drive does not follow role");
  property p_irqMask; s_ctrlWr ##0 !writedata[CTRL_IRQ_EN] |=> !irq; endproperty
  a_irqMask: assert property (p_irqMask) else $error("masked interrupt raised");
  property p_irqCause; $rose(irq) |-> ctrl_q[CTRL_IRQ_EN]; endproperty
  a_irqCause: assert property (p_irqCause) else $error("interrupt while disabled");
  // Extension bits 00 only; codes 0110 to 1011 toggle later than this window
  property p_start;
    s_dataWr ##0 ctrl_q[CTRL_PORT_EN] && ctrl_q[CTRL_MASTER] && ext_q[1:0] == 2'b00 |-> ##[2:40] $changed(pins.sckOut);
  endproperty
  a_start: assert property (p_start) else $error("data write started no clock");
  property p_idle; s_ctrlWr ##0 writedata[CTRL_PORT_EN] && writedata[CTRL_MASTER] |=> ##2 pins.sckOut == ctrl_q[CTRL_CLOCK_IDLE_POLARITY]; endproperty
  a_idle: assert property (p_idle) else $error("idle clock level wrong");
endmodule : spm_chk
`default_nettype wire

// ===== verif/spm_peer.sv
// Purpose: far SPI device, shifts one byte each frame
// Assumes: load comes before the first clock edge
// Notes:   line toggles outside frames
`timescale 1ns/1ps
`default_nettype none
module spm_peer (
  // Clock
  input wire logic        ref_clk,
  // Link
  input wire logic        sck,
  input wire logic        sdo,
  input wire logic        clock_idle_polarity,
  input wire logic        clock_phase_select,
  input wire logic        load,
  input wire logic [7:0]  tx,
  output logic            sdi,
  output logic [7:0]      rx
);
  logic       sckPrev = 1'b0;
  logic [3:0] cnt     = 4'h8;
  initial sdi = 1'b0;
  initial rx = 8'h00;
  always @(posedge ref_clk)
  begin
    sckPrev <= sck;
    if (load)
    begin
      cnt <= 4'h0;
      sdi <= tx[7];
    end
    else if (sck != sckPrev && cnt != 4'h8)
    begin
      if ((sck != clock_idle_polarity) ^ clock_phase_select)
      begin
        rx <= {rx[6:0], sdo};
        cnt <= cnt + 4'h1;
      end
      else
        sdi <= tx[3'h7 - cnt[2:0]];
    end
    else if (cnt == 4'h8)
      sdi <= ~sdi;
  end
endmodule : spm_peer
`default_nettype wire

// ===== verif/tb_spi_master_slave_port.sv
// Purpose: register-level tests of spm_port
// Assumes: accesses wait for waitrequest low at a rising edge
// Notes:   master uses codes 0010 and 0011
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_port;
  import spm_pkg::*;
  logic         ref_clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, sckIn = 1'b0, load = 1'b0;
  logic [15:0]  address = 16'h0000;
  logic [31:0]  writedata = 32'h0, readdata;
  logic         waitrequest, irq, sdiIn;
  spm_pins_type pins;
  logic [7:0]   ctrl = 8'h00, tx = 8'h00, rx, q;
  int           err_total = 0, checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  spm_port spm_port_inst (.ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .sckIn(sckIn), .sdiIn(sdiIn), .pins(pins), .irq(irq));
  spm_peer spm_peer_inst (.ref_clk(ref_clk), .sck(ctrl[4] ? pins.sckOut : sckIn),
    .sdo(pins.sdoOe ? pins.sdoOut : ~rx[0]), .clock_idle_polarity(ctrl[3]), .clock_phase_select(ctrl[2]), .load(load), .tx(tx),
    .sdi(sdiIn), .rx(rx));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge ref_clk);
    address <= a;
    read <= ~w;
    write <= w;
    writedata <= {24'h0, d};
    // Only the watchdog ends a wait that never finishes
    do
      @(posedge ref_clk);
    while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk(q, e);
  endtask : rd
  task automatic pload(input logic [7:0] d);
    @(posedge ref_clk);
    tx <= d;
    load <= 1'b1;
    @(posedge ref_clk);
    load <= 1'b0;
  endtask : pload
  task automatic clk16();
    repeat (16)
    begin
      repeat (6) @(posedge ref_clk);
      sckIn <= ~sckIn;
    end
  endtask : clk16
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (10000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(ADR_CTRL, CTRL_RST);
    rd(ADR_EXT, EXT_RST);
    rd(16'h0040, 8'h00);
    acc(ADR_CTRL, 1'b1, 8'h90);
    acc(ADR_DATA, 1'b1, 8'hFF);
    repeat (100) @(posedge ref_clk);
    rd(ADR_STAT, 8'h00);
    acc(ADR_EXT, 1'b1, 8'h00);
    $display("reset and disable test done");
    for (int m = 0; m < 4; m++)
    begin
      ctrl = {m[1] ^ m[0], 3'b101, m[1:0], 1'b1, m[1]};
      acc(ADR_CTRL, 1'b1, ctrl);
      repeat (4) @(posedge ref_clk);
      chk(pins.sckOut, ctrl[3]);
      pload(8'h96 ^ m[7:0]);
      acc(ADR_DATA, 1'b1, 8'h3C + m[7:0]);
      // Second write while busy is refused and flagged
      if (m == 3)
        acc(ADR_DATA, 1'b1, 8'h00);
      repeat (300) @(posedge ref_clk);
      chk(irq, ctrl[7]);
      chk(pins.sckOut, ctrl[3]);
      rd(ADR_STAT, {1'b1, m == 3, 6'h00});
      // Interrupt falls only after the clearing edge
      @(posedge ref_clk);
      chk(irq, 1'b0);
      rd(ADR_DATA, tx);
      chk(rx, 8'h3C + m[7:0]);
      $display("master mode %0d done", m);
    end
    for (int m = 0; m < 4; m++)
    begin
      ctrl = {4'h4, m[1:0], 2'b10};
      sckIn <= ctrl[3];
      acc(ADR_CTRL, 1'b1, ctrl);
      if (m == 0)
      begin
        clk16();
        repeat (4) @(posedge ref_clk);
        chk(pins.sdoOe, 1'b0);
        rd(ADR_STAT, 8'h00);
      end
      pload(8'h5A ^ m[7:0]);
      acc(ADR_DATA, 1'b1, 8'hC3 ^ m[7:0]);
      clk16();
      repeat (4) @(posedge ref_clk);
      rd(ADR_STAT, 8'h80);
      rd(ADR_DATA, tx);
      chk(rx, 8'hC3 ^ m[7:0]);
      $display("slave mode %0d done", m);
    end
    conclude();
  end
endmodule : tb_spi_master_slave_port
bind spm_port spm_chk spm_chk_inst (.ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .pins(pins), .irq(irq));
`default_nettype wire
